// ==== rtl/srpc_system_reset_power_control.sv ====
`timescale 1ns/10ps
// Behaviour
// - Interrupt enable register at 0x0020, reset 0x1FFE, gates interrupt output for all but the test interrupt.
// - Writing one to enable bit 15 raises test interrupt; bit self-clears, reads zero.
// - Hardware-reset interrupt enable bit 12 resets to one.
// - Bit 0 at 0x8810 reinitialises the whole chip, then self-clears.
// - Power-down bit at 0x8812 holds low-power mode while one.
// - Register access keeps working during power-down.
// - Power-down bit reset value comes from strap pin.
// - Bit 0 at 0x8814 resets PHY subsystem, clears after completion.
// - Bit 0 at 0x8815 resets PHY-MAC interface, clears after completion.
// - Status bit 1 at 0x8818 reads one while actually powered down.
// - Status bit 0 at 0x8818 reads one in normal operation after start-up, zero in power-down; resets zero.
// - Bit 0 at 0x8819 forces boot oscillator clock on; resets zero.
// - Bit 0 at 0x882C enables diagnostics clock; register resets 0x0002.
// - Status bits latch events until the status register is read.
// - Status bits latch regardless of enable bits.
module srpc_system_reset_power_control (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic power_down_strap_pin_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [srpc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [srpc_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [srpc_pkg::DATA_W-1:0] reg_rdata_out,
  output logic irq_out,
  output logic soft_power_down_out,
  output logic chip_reset_out,
  output logic phy_reset_out,
  output logic mac_if_reset_out,
  output logic boot_osc_force_out,
  output logic diag_clk_en_out
);
  import srpc_pkg::*;

  typedef enum logic [1:0] {SRPC_BOOT, SRPC_RUN, SRPC_PD, SRPC_CHIPRST} srpc_state_t;

  logic strap_s1_q, strap_s2_q;
  srpc_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] phy_cnt_q, phy_cnt_d;
  logic [CNT_W-1:0] mac_cnt_q, mac_cnt_d;
  logic [15:0] irq_en_q, irq_en_d;
  logic [15:0] irq_stat_q, irq_stat_d;
  logic pd_q, pd_d;
  logic osc_q, osc_d;
  logic [15:0] diag_q, diag_d;
  logic [15:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic boot_load_q, boot_load_d;
  logic sw_irq_req;
  logic hw_rst_evt;

  function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] ofs, input logic we);
    wr_hit = we && (a == ofs);
  endfunction

  // Strap comes from a pin, so synchronise before use
  always_ff @(posedge clk_in) begin
    strap_s1_q <= power_down_strap_pin_in;
    strap_s2_q <= strap_s1_q;
  end

  assign sw_irq_req = wr_hit(reg_addr_in, OFS_IRQ_ENABLE, reg_wr_in) && reg_wdata_in[BIT_SW_IRQ];
  // First boot cycle after hardware reset or soft chip reset counts as the hardware-reset event
  assign hw_rst_evt = (state_q == SRPC_BOOT) && (cnt_q == CNT_W'(0)) && boot_load_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    phy_cnt_d = phy_cnt_q;
    mac_cnt_d = mac_cnt_q;
    irq_en_d = irq_en_q;
    irq_stat_d = irq_stat_q;
    pd_d = pd_q;
    osc_d = osc_q;
    diag_d = diag_q;
    boot_load_d = 1'b0;
    rdata_d = rdata_q;
    unique case (state_q)
      SRPC_BOOT: begin
        if (boot_load_q) begin
          pd_d = strap_s2_q;
        end
        if (cnt_q == CNT_W'(STARTUP_CYC - 1)) begin
          state_d = pd_d ? SRPC_PD : SRPC_RUN;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      SRPC_RUN: begin
        if (pd_q) begin
          state_d = SRPC_PD;
        end
      end
      SRPC_PD: begin
        if (!pd_q) begin
          state_d = SRPC_RUN;
        end
      end
      SRPC_CHIPRST: begin
        if (cnt_q == CNT_W'(CHIPRST_CYC - 1)) begin
          state_d = SRPC_BOOT;
          cnt_d = '0;
          boot_load_d = 1'b1;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
    endcase
    if (phy_cnt_q != '0) begin
      phy_cnt_d = phy_cnt_q - CNT_W'(1);
    end
    if (mac_cnt_q != '0) begin
      mac_cnt_d = mac_cnt_q - CNT_W'(1);
    end
    // Reads are served in every state, power-down included
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFS_IRQ_STATUS: rdata_d = irq_stat_q;
        OFS_IRQ_ENABLE: rdata_d = irq_en_q & IRQ_ENABLE_WMASK;
        OFS_CHIP_RST: rdata_d = {15'h0000, state_q == SRPC_CHIPRST};
        OFS_PD_CTRL: rdata_d = {15'h0000, pd_q};
        OFS_PHY_RST: rdata_d = {15'h0000, phy_cnt_q != '0};
        OFS_MACIF_RST: rdata_d = {15'h0000, mac_cnt_q != '0};
        OFS_STATE: rdata_d = {14'h0000, state_q == SRPC_PD, state_q == SRPC_RUN};
        OFS_PMG_CTRL: rdata_d = {15'h0000, osc_q};
        OFS_DIAG_CLK: rdata_d = diag_q;
        default: rdata_d = 16'h0000;
      endcase
      if (reg_addr_in == OFS_IRQ_STATUS) begin
        irq_stat_d = 16'h0000;
      end
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        OFS_IRQ_ENABLE: irq_en_d = reg_wdata_in & IRQ_ENABLE_WMASK;
        OFS_PD_CTRL: pd_d = reg_wdata_in[0];
        OFS_PHY_RST: if (reg_wdata_in[0]) phy_cnt_d = CNT_W'(SUBRST_CYC);
        OFS_MACIF_RST: if (reg_wdata_in[0]) mac_cnt_d = CNT_W'(SUBRST_CYC);
        OFS_PMG_CTRL: osc_d = reg_wdata_in[0];
        OFS_DIAG_CLK: diag_d = {diag_q[15:1], reg_wdata_in[0]};
        OFS_CHIP_RST: begin
          if (reg_wdata_in[0]) begin
            state_d = SRPC_CHIPRST;
            cnt_d = '0;
          end
        end
        default: ;
      endcase
    end
    // Event set wins over the clear-on-read in the same cycle
    if (sw_irq_req) begin
      irq_stat_d[BIT_SW_IRQ] = 1'b1;
    end
    if (hw_rst_evt) begin
      irq_stat_d[BIT_HW_RST_IRQ] = 1'b1;
    end
    // Soft chip reset reinitialises control state like hardware reset
    if (state_q == SRPC_CHIPRST) begin
      irq_en_d = RST_IRQ_ENABLE;
      osc_d = 1'b0;
      diag_d = RST_DIAG_CLK;
      phy_cnt_d = '0;
      mac_cnt_d = '0;
    end
    irq_d = |(irq_stat_d & irq_en_d & IRQ_STATUS_MASK) || irq_stat_d[BIT_SW_IRQ];
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= SRPC_BOOT;
      cnt_q <= '0;
      phy_cnt_q <= '0;
      mac_cnt_q <= '0;
      irq_en_q <= RST_IRQ_ENABLE;
      irq_stat_q <= 16'h0000;
      pd_q <= 1'b0;
      osc_q <= 1'b0;
      diag_q <= RST_DIAG_CLK;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
      boot_load_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      phy_cnt_q <= phy_cnt_d;
      mac_cnt_q <= mac_cnt_d;
      irq_en_q <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      pd_q <= pd_d;
      osc_q <= osc_d;
      diag_q <= diag_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      boot_load_q <= boot_load_d;
    end
  end

  logic sdpd_q, chip_rst_q, phy_rst_q, mac_rst_q;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sdpd_q <= 1'b0;
      chip_rst_q <= 1'b0;
      phy_rst_q <= 1'b0;
      mac_rst_q <= 1'b0;
    end else begin
      sdpd_q <= (state_d == SRPC_PD);
      chip_rst_q <= (state_d == SRPC_CHIPRST);
      phy_rst_q <= (phy_cnt_d != '0);
      mac_rst_q <= (mac_cnt_d != '0);
    end
  end

  assign reg_rdata_out = rdata_q;
  assign irq_out = irq_q;
  assign soft_power_down_out = sdpd_q;
  assign chip_reset_out = chip_rst_q;
  assign phy_reset_out = phy_rst_q;
  assign mac_if_reset_out = mac_rst_q;
  assign boot_osc_force_out = osc_q;
  assign diag_clk_en_out = diag_q[0];

  // Pulse lengths for the checks; too long to spell out as a repetition
  logic [CNT_W-1:0] chip_len_q, chip_len_d;
  logic [CNT_W-1:0] phy_len_q, phy_len_d;
  always_comb begin
    chip_len_d = chip_reset_out ? chip_len_q + CNT_W'(1) : '0;
    phy_len_d = phy_reset_out ? phy_len_q + CNT_W'(1) : '0;
  end
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      chip_len_q <= '0;
      phy_len_q <= '0;
    end else begin
      chip_len_q <= chip_len_d;
      phy_len_q <= phy_len_d;
    end
  end

  chk_irq_follows: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(irq_stat_q[BIT_HW_RST_IRQ]) && irq_en_q[BIT_HW_RST_IRQ] |-> irq_out)
    else $error("irq not raised for enabled latched event");
  chk_masked_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !irq_stat_q[BIT_SW_IRQ] && !(irq_stat_q[BIT_HW_RST_IRQ] && irq_en_q[BIT_HW_RST_IRQ])
    |-> !irq_out)
    else $error("irq active with nothing enabled and latched");
  chk_sw_irq_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sw_irq_req |=> irq_stat_q[BIT_SW_IRQ] && irq_out)
    else $error("sw test irq not latched");
  chk_sw_bit_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
    reg_rd_in && reg_addr_in == OFS_IRQ_ENABLE |=> !reg_rdata_out[BIT_SW_IRQ])
    else $error("sw request bit read nonzero");
  chk_en_restore: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_q == SRPC_CHIPRST |=> irq_en_q == RST_IRQ_ENABLE)
    else $error("interrupt enables not restored by chip reset");
  chk_stat_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    reg_rd_in && reg_addr_in == OFS_IRQ_STATUS && !sw_irq_req && !hw_rst_evt
    |=> irq_stat_q == 16'h0000)
    else $error("status not cleared by read");
  chk_stat_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    irq_stat_q[BIT_SW_IRQ] && !(reg_rd_in && reg_addr_in == OFS_IRQ_STATUS)
    |=> irq_stat_q[BIT_SW_IRQ])
    else $error("latched status lost");
  chk_chip_rst_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(chip_reset_out) |-> chip_reset_out [*8])
    else $error("chip reset too short");
  chk_chip_rst_time: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(chip_reset_out) |-> chip_len_q >= CNT_W'(CHIPRST_CYC))
    else $error("chip reset shorter than its count");
  chk_phy_rst_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_hit(reg_addr_in, OFS_PHY_RST, reg_wr_in) && reg_wdata_in[0] && state_q != SRPC_CHIPRST
    |=> phy_reset_out ##[1:20] !phy_reset_out)
    else $error("phy reset did not self clear");
  chk_phy_rst_time: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(phy_reset_out) && !chip_reset_out |-> phy_len_q >= CNT_W'(SUBRST_CYC))
    else $error("phy reset shorter than its count");
  chk_mac_rst_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_hit(reg_addr_in, OFS_MACIF_RST, reg_wr_in) && reg_wdata_in[0] && state_q != SRPC_CHIPRST
    |=> mac_if_reset_out ##[1:20] !mac_if_reset_out)
    else $error("mac if reset did not self clear");
  chk_pd_entry: assert property (@(posedge clk_in) disable iff (!resetn_in)
    pd_q && state_q == SRPC_RUN && !reg_wr_in |=> soft_power_down_out)
    else $error("power-down not entered");
  chk_strap_load: assert property (@(posedge clk_in) disable iff (!resetn_in)
    boot_load_q && !reg_wr_in |=> pd_q == $past(strap_s2_q))
    else $error("power-down bit not loaded from strap");
  chk_pd_status: assert property (@(posedge clk_in) disable iff (!resetn_in)
    reg_rd_in && reg_addr_in == OFS_STATE |=> reg_rdata_out[BIT_PD_REACHED] == $past(sdpd_q))
    else $error("power-down status mismatch");
  chk_ready_boot: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_q == SRPC_BOOT && reg_rd_in && reg_addr_in == OFS_STATE
    |=> !reg_rdata_out[BIT_SYS_READY])
    else $error("ready during start-up");
  chk_ready_run: assert property (@(posedge clk_in) disable iff (!resetn_in)
    state_q == SRPC_RUN && reg_rd_in && reg_addr_in == OFS_STATE |=> reg_rdata_out[BIT_SYS_READY])
    else $error("ready missing in normal operation");
  chk_diag_fixed: assert property (@(posedge clk_in) disable iff (!resetn_in)
    diag_q[15:1] == RST_DIAG_CLK[15:1])
    else $error("diagnostics clock reserved bits changed");
  cov_sw_irq: cover property (@(posedge clk_in) sw_irq_req ##1 irq_out);
  cov_pd_entry: cover property (@(posedge clk_in) $rose(soft_power_down_out));
  cov_chip_rst: cover property (@(posedge clk_in) $fell(chip_reset_out));
  cov_phy_rst: cover property (@(posedge clk_in) $fell(phy_reset_out));
  cov_mac_rst: cover property (@(posedge clk_in) $fell(mac_if_reset_out));

endmodule // srpc_system_reset_power_control

// ==== rtl/srpc_pkg.sv ====
package srpc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h0010;
  localparam logic [15:0] OFS_IRQ_ENABLE = 16'h0020;
  localparam logic [15:0] OFS_CHIP_RST = 16'h8810;
  localparam logic [15:0] OFS_PD_CTRL = 16'h8812;
  localparam logic [15:0] OFS_PHY_RST = 16'h8814;
  localparam logic [15:0] OFS_MACIF_RST = 16'h8815;
  localparam logic [15:0] OFS_STATE = 16'h8818;
  localparam logic [15:0] OFS_PMG_CTRL = 16'h8819;
  localparam logic [15:0] OFS_DIAG_CLK = 16'h882C;
  localparam logic [15:0] RST_IRQ_ENABLE = 16'h1FFE;
  localparam logic [15:0] RST_DIAG_CLK = 16'h0002;
  localparam logic [15:0] IRQ_ENABLE_WMASK = 16'h1FFF;
  localparam logic [15:0] IRQ_STATUS_MASK = 16'h9000;
  localparam int BIT_SW_IRQ = 15;
  localparam int BIT_HW_RST_IRQ = 12;
  localparam int BIT_PD_REACHED = 1;
  localparam int BIT_SYS_READY = 0;
  localparam int STARTUP_NS = 400;
  localparam int CLK_NS = 4;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUBRST_NS = 64;
  localparam int SUBRST_CYC = (SUBRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CHIPRST_NS = 128;
  localparam int CHIPRST_CYC = (CHIPRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
endpackage

// ==== verification/srpc_host_model.sv ====
`timescale 1ns/10ps
module srpc_host_model (
  input wire logic clk_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [srpc_pkg::ADDR_W-1:0] reg_addr_out,
  output logic [srpc_pkg::DATA_W-1:0] reg_wdata_out,
  input wire logic [srpc_pkg::DATA_W-1:0] reg_rdata_in
);
  import srpc_pkg::*;
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 16'h0000;
    reg_wdata_out = 16'h0000;
  end
  // Idle bus shows the inverse of the last value, so a stale copy never matches
  task automatic release_bus(input int gap);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~reg_addr_out;
    reg_wdata_out <= ~reg_wdata_out;
    repeat (gap) @(posedge clk_in);
  endtask
  task automatic write(input logic [15:0] a, input logic [15:0] d, input int gap);
    @(posedge clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clk_in);
    release_bus(gap);
  endtask
  task automatic read(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clk_in);
    release_bus(0);
    @(posedge clk_in);
    #1;
    d = reg_rdata_in;
  endtask
endmodule // srpc_host_model

// ==== verification/srpc_testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import srpc_pkg::*;
  logic clk_in;
  logic resetn_in = 1'b0;
  logic strap = 1'b0;
  logic reg_wr, reg_rd, irq, pd, chip_rst, phy_rst, mac_rst, osc, diag;
  logic [15:0] addr, wdata, rdata, rd;
  logic [1:0] sub;
  int miscompares = 0;
  int total_checks = 0;
  assign sub = {mac_rst, phy_rst};
  srpc_host_model i_host (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
  srpc_system_reset_power_control i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .power_down_strap_pin_in(strap), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .irq_out(irq),
    .soft_power_down_out(pd), .chip_reset_out(chip_rst), .phy_reset_out(phy_rst),
    .mac_if_reset_out(mac_rst), .boot_osc_force_out(osc), .diag_clk_en_out(diag));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
    i_host.read(a, rd);
    chk_word(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    strap <= s;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    tick(120);
  endtask
  task automatic t_reset_values();
    chk_bit(irq, 1'b1);
    chk_rd(OFS_IRQ_ENABLE, 16'h1FFE);
    chk_rd(OFS_CHIP_RST, 16'h0000);
    chk_rd(OFS_PD_CTRL, 16'h0000);
    chk_rd(OFS_STATE, 16'h0001);
    chk_rd(OFS_PMG_CTRL, 16'h0000);
    chk_rd(OFS_DIAG_CLK, 16'h0002);
    chk_rd(16'h8811, 16'h0000);
    // Mask the latched reset event: output drops, status must survive
    i_host.write(OFS_IRQ_ENABLE, 16'h0000, 0);
    tick(2);
    chk_bit(irq, 1'b0);
    i_host.write(OFS_IRQ_ENABLE, 16'h1FFE, 0);
    tick(2);
    chk_bit(irq, 1'b1);
    chk_rd(OFS_IRQ_STATUS, 16'h1000);
    chk_bit(irq, 1'b0);
    chk_rd(OFS_IRQ_STATUS, 16'h0000);
  endtask
  task automatic t_sw_irq();
    i_host.write(OFS_IRQ_ENABLE, 16'h8000, 0);
    tick(2);
    chk_bit(irq, 1'b1);
    chk_rd(OFS_IRQ_ENABLE, 16'h0000);
    chk_bit(irq, 1'b1);
    chk_rd(OFS_IRQ_STATUS, 16'h8000);
    chk_bit(irq, 1'b0);
  endtask
  task automatic t_chip_reset();
    // Hardware-reset enable cleared first: reinit must restore it
    i_host.write(OFS_IRQ_ENABLE, 16'h0FFE, 3);
    i_host.write(OFS_CHIP_RST, 16'h0001, 0);
    tick(2);
    chk_bit(chip_rst, 1'b1);
    tick(40);
    chk_rd(OFS_STATE, 16'h0000);
    tick(110);
    chk_bit(chip_rst, 1'b0);
    chk_rd(OFS_CHIP_RST, 16'h0000);
    chk_rd(OFS_IRQ_ENABLE, 16'h1FFE);
    chk_bit(irq, 1'b1);
    chk_rd(OFS_IRQ_STATUS, 16'h1000);
    chk_rd(OFS_STATE, 16'h0001);
  endtask
  task automatic t_sub_reset(input logic [15:0] a, input int k);
    i_host.write(a, 16'h0001, 0);
    tick(2);
    chk_bit(sub[k], 1'b1);
    chk_bit(sub[1-k], 1'b0);
    chk_bit(chip_rst, 1'b0);
    chk_rd(a, 16'h0001);
    tick(20);
    chk_bit(sub[k], 1'b0);
    chk_rd(a, 16'h0000);
  endtask
  task automatic t_power_down();
    i_host.write(OFS_PD_CTRL, 16'hFFFF, 0);
    tick(8);
    chk_bit(pd, 1'b1);
    chk_rd(OFS_STATE, 16'h0002);
    i_host.write(OFS_PMG_CTRL, 16'hFFFF, 0);
    i_host.write(OFS_DIAG_CLK, 16'hFFFF, 0);
    tick(2);
    chk_bit(osc, 1'b1);
    chk_bit(diag, 1'b1);
    chk_rd(OFS_PMG_CTRL, 16'h0001);
    chk_rd(OFS_DIAG_CLK, 16'h0003);
    chk_rd(OFS_PD_CTRL, 16'h0001);
    i_host.write(OFS_PD_CTRL, 16'h0000, 0);
    tick(120);
    chk_bit(pd, 1'b0);
    chk_rd(OFS_STATE, 16'h0001);
  endtask
  task automatic t_strap();
    do_reset(1'b1);
    chk_bit(osc, 1'b0);
    chk_rd(OFS_PD_CTRL, 16'h0001);
    chk_bit(pd, 1'b1);
    chk_rd(OFS_STATE, 16'h0002);
  endtask
  initial begin
    do_reset(1'b0);
    t_reset_values();
    t_sw_irq();
    t_chip_reset();
    t_sub_reset(OFS_PHY_RST, 0);
    t_sub_reset(OFS_MACIF_RST, 1);
    t_power_down();
    t_strap();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    finish_test();
  end
endmodule // testbench
